// *** shared/cpt_cfg.svh ***
`ifndef CPT_CFG_SVH
`define CPT_CFG_SVH

// Register byte offsets on the APB slave
`define CPT_OFS_CTRL0 8'h00
`define CPT_OFS_CTRL1 8'h04
`define CPT_OFS_CNT_LO 8'h08
`define CPT_OFS_CNT_HI 8'h0c
`define CPT_OFS_CMPA_LO 8'h10
`define CPT_OFS_CMPA_HI 8'h14
`define CPT_OFS_FLAGS 8'h18

// Control byte 0 fields
`define CPT_C0_ON 3
`define CPT_C0_PER_HI 2
`define CPT_C0_PER_LO 0
`define CPT_C0_MASK 8'h0f

// Control byte 1 fields
`define CPT_C1_MODE_HI 7
`define CPT_C1_MODE_LO 6
`define CPT_C1_ACT_HI 5
`define CPT_C1_ACT_LO 4
`define CPT_C1_OC 3
`define CPT_C1_POL 2
`define CPT_C1_SWAP 1
`define CPT_C1_CLRSEL 0

// Flag register fields
`define CPT_FL_A 0
`define CPT_FL_P 1

// Reset values
`define CPT_RST_BYTE 8'h00
`define CPT_RST_CMPA 10'h000
`define CPT_RST_CNT 10'h000

// Period granule: the period field is compared with the top bits
`define CPT_PER_SHIFT 7

`endif

// *** shared/cpt_pkg.sv ***
package cpt_pkg;

   typedef enum logic [1:0] {
      CPT_MODE_CMP = 2'h0,
      CPT_MODE_UNDEF = 2'h1,
      CPT_MODE_PWM = 2'h2,
      CPT_MODE_TMR = 2'h3
   } cpt_mode_t;

   typedef enum logic [1:0] {
      CPT_ACT_NONE = 2'h0,
      CPT_ACT_LOW = 2'h1,
      CPT_ACT_HIGH = 2'h2,
      CPT_ACT_TOGGLE = 2'h3
   } cpt_action_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } cpt_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cpt_apb_rsp_t;

endpackage : cpt_pkg

// *** rtl/cpt_count.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpt_cfg.svh"

module cpt_count
   import cpt_pkg::*;
#(
   parameter int CNT_W = 10,
   parameter int PER_W = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic run,
   input wire logic restart,
   input wire logic clearOnA,
   input wire logic [CNT_W-1:0] compareA,
   input wire logic [PER_W-1:0] periodField,
   output logic [CNT_W-1:0] count,
   output logic hitA,
   output logic hitP
);

   generate
      if (CNT_W != PER_W + `CPT_PER_SHIFT) begin : g_bad
         $error("cpt_count: counter width must equal period field width plus granule");
      end
   endgenerate

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cpt_cnt_state_t;

   cpt_cnt_state_t state;
   cpt_cnt_state_t next_state;
   logic [CNT_W-1:0] incremented;

   // Hits look at the value about to be loaded, so a clear lands exactly on the period
   assign incremented = CNT_W'(state.count + 1'b1);
   assign hitA = run && !restart && (incremented == compareA);
   assign hitP = run && !restart && (incremented[CNT_W-1:`CPT_PER_SHIFT] == periodField)
      && (incremented[`CPT_PER_SHIFT-1:0] == '0);
   assign count = state.count;

   always_comb begin
      next_state = state;
      if (restart) begin
         next_state.count = '0;
      end else if (run) begin
         if (clearOnA ? hitA : hitP) begin
            next_state.count = '0;
         end else begin
            next_state.count = incremented;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state.count <= `CPT_RST_CNT;
      end else begin
         state <= next_state;
      end
   end

endmodule : cpt_count
`default_nettype wire

// *** rtl/cpt_timer.sv ***
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cpt_cfg.svh"

// Function
// - Counter readable as low byte, high two bits
// - Compare-A value writable, ten bits, split bytes
// - Mode 00 compare, 10 PWM, 11 timer
// - Clear-select low: P clears, both flags
// - Clear-select high: A clears, A flag only
// - Compare-A zero, clear-select high outside PWM: overflow, no A flag
// - Compare output changes only on A match or timer-on rise
// - A match sets, clears, toggles or holds output
// - Timer-on rise loads output-control level
// - Timer mode counts alike, pin not driven
// - PWM ignores clear-select bit
// - Swap zero: P period, A duty
// - Swap one: A period, P duty
// - Duty at or above period: always active
// - PWM sets flags on each match
// - Forced PWM levels keep counter running
// - Output control picks active level; polarity inverts
// - Compare actions: 01 low, 10 high, 11 toggle
// - PWM actions: 00 inactive, 01 active, 10 waveform
// - Timer-on rise zeroes counter; fall holds it
// - P match when field equals top three bits
module cpt_timer
   import cpt_pkg::*;
#(
   parameter int CNT_W = 10,
   parameter int PER_W = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire cpt_apb_req_t apbReq,
   output cpt_apb_rsp_t apbRsp,
   output logic compareAFlag,
   output logic comparePFlag,
   output logic timerPinOut,
   output logic timerPinOe
);

   generate
      if (CNT_W > 16 || PER_W < 1) begin : g_bad
         $error("cpt_timer: counter must fit two bytes and period field must exist");
      end
   endgenerate

   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [CNT_W-1:0] compareA;
      logic flagA;
      logic flagP;
      logic onDelayed;
      logic outLevel;
      logic pinOut;
      logic pinOe;
      logic [31:0] rdata;
   } cpt_main_t;

   cpt_main_t state;
   cpt_main_t next_state;

   logic timerOn;
   logic onRise;
   logic run;
   logic [PER_W-1:0] periodField;
   cpt_mode_t mode;
   cpt_action_t action;
   logic outputControl;
   logic outputPolarity;
   logic periodDutySwap;
   logic clearSelect;
   logic clearOnA;
   logic [CNT_W-1:0] count;
   logic hitA;
   logic hitP;
   logic eventA;
   logic eventP;
   logic [CNT_W:0] dutyValue;
   logic pwmActive;
   logic setup;
   logic access;
   logic writeTaken;
   logic mapped;

   function automatic logic isPwm(input cpt_mode_t m);
      return m == CPT_MODE_PWM;
   endfunction : isPwm

   // Mode 01 is undefined; it counts like compare mode but leaves the pin alone
   function automatic logic isCompareLike(input cpt_mode_t m);
      return m != CPT_MODE_PWM;
   endfunction : isCompareLike

   function automatic logic isMapped(input logic [7:0] a);
      return a == `CPT_OFS_CTRL0 || a == `CPT_OFS_CTRL1 || a == `CPT_OFS_CNT_LO
         || a == `CPT_OFS_CNT_HI || a == `CPT_OFS_CMPA_LO || a == `CPT_OFS_CMPA_HI
         || a == `CPT_OFS_FLAGS;
   endfunction : isMapped

   assign timerOn = state.ctrl0[`CPT_C0_ON];
   assign periodField = state.ctrl0[`CPT_C0_PER_LO +: PER_W];
   assign mode = cpt_mode_t'(state.ctrl1[`CPT_C1_MODE_HI:`CPT_C1_MODE_LO]);
   assign action = cpt_action_t'(state.ctrl1[`CPT_C1_ACT_HI:`CPT_C1_ACT_LO]);
   assign outputControl = state.ctrl1[`CPT_C1_OC];
   assign outputPolarity = state.ctrl1[`CPT_C1_POL];
   assign periodDutySwap = state.ctrl1[`CPT_C1_SWAP];
   assign clearSelect = state.ctrl1[`CPT_C1_CLRSEL];

   assign onRise = timerOn && !state.onDelayed;
   assign run = timerOn;

   // PWM ignores clear-select and follows the swap bit instead
   assign clearOnA = isPwm(mode) ? periodDutySwap : clearSelect;

   cpt_count #(
      .CNT_W(CNT_W),
      .PER_W(PER_W)
   ) u_count (
      .clock(clock),
      .rst(rst),
      .run(run),
      .restart(onRise),
      .clearOnA(clearOnA),
      .compareA(state.compareA),
      .periodField(periodField),
      .count(count),
      .hitA(hitA),
      .hitP(hitP)
   );

   // A hit at compare-A zero is the overflow wrap, not a real match, when clear-select has A clear outside PWM
   assign eventA = hitA && !(isCompareLike(mode) && clearSelect && state.compareA == '0);
   assign eventP = hitP && (isPwm(mode) || !clearSelect);

   // Period field zero stands for a full counter span
   always_comb begin
      if (periodDutySwap) begin
         dutyValue = (periodField == '0) ? (CNT_W+1)'(1) << CNT_W
            : {1'b0, periodField, {`CPT_PER_SHIFT{1'b0}}};
      end else begin
         dutyValue = {1'b0, state.compareA};
      end
   end

   // The counter never reaches the period, so a duty at or above it stays active
   assign pwmActive = {1'b0, count} < dutyValue;

   assign setup = apbReq.psel && !apbReq.penable;
   assign access = apbReq.psel && apbReq.penable;
   assign writeTaken = access && apbReq.pwrite && isMapped(apbReq.paddr);
   assign mapped = isMapped(apbReq.paddr);

   always_comb begin
      next_state = state;
      next_state.onDelayed = timerOn;

      // Flags: hardware set wins over a same-cycle software clear
      if (writeTaken && apbReq.paddr == `CPT_OFS_FLAGS) begin
         if (apbReq.pwdata[`CPT_FL_A]) begin
            next_state.flagA = 1'b0;
         end
         if (apbReq.pwdata[`CPT_FL_P]) begin
            next_state.flagP = 1'b0;
         end
      end
      if (eventA) begin
         next_state.flagA = 1'b1;
      end
      if (eventP) begin
         next_state.flagP = 1'b1;
      end

      if (writeTaken) begin
         case (apbReq.paddr)
            `CPT_OFS_CTRL0: begin
               next_state.ctrl0 = apbReq.pwdata[7:0] & `CPT_C0_MASK;
            end
            `CPT_OFS_CTRL1: begin
               next_state.ctrl1 = apbReq.pwdata[7:0];
            end
            `CPT_OFS_CMPA_LO: begin
               next_state.compareA[7:0] = apbReq.pwdata[7:0];
            end
            `CPT_OFS_CMPA_HI: begin
               next_state.compareA[CNT_W-1:8] = apbReq.pwdata[CNT_W-9:0];
            end
            default: begin
            end
         endcase
      end

      // Compare output level
      if (onRise) begin
         next_state.outLevel = outputControl;
      end else if (eventA && mode == CPT_MODE_CMP) begin
         case (action)
            CPT_ACT_LOW: next_state.outLevel = 1'b0;
            CPT_ACT_HIGH: next_state.outLevel = 1'b1;
            CPT_ACT_TOGGLE: next_state.outLevel = !state.outLevel;
            default: next_state.outLevel = state.outLevel;
         endcase
      end

      // Pin: forced PWM levels only mask the pin, the counter keeps going
      next_state.pinOe = (mode == CPT_MODE_CMP) || isPwm(mode);
      if (isPwm(mode)) begin
         case (action)
            CPT_ACT_LOW: next_state.pinOut = outputControl ^ outputPolarity;
            CPT_ACT_HIGH: next_state.pinOut = (pwmActive ? outputControl : !outputControl) ^ outputPolarity;
            default: next_state.pinOut = !outputControl ^ outputPolarity;
         endcase
      end else if (mode == CPT_MODE_CMP) begin
         next_state.pinOut = next_state.outLevel ^ outputPolarity;
      end else begin
         next_state.pinOut = 1'b0;
      end

      // Read data captured in the setup phase, held through the access phase
      if (setup) begin
         next_state.rdata = '0;
         case (apbReq.paddr)
            `CPT_OFS_CTRL0: next_state.rdata[7:0] = state.ctrl0;
            `CPT_OFS_CTRL1: next_state.rdata[7:0] = state.ctrl1;
            `CPT_OFS_CNT_LO: next_state.rdata[7:0] = count[7:0];
            `CPT_OFS_CNT_HI: next_state.rdata[CNT_W-9:0] = count[CNT_W-1:8];
            `CPT_OFS_CMPA_LO: next_state.rdata[7:0] = state.compareA[7:0];
            `CPT_OFS_CMPA_HI: next_state.rdata[CNT_W-9:0] = state.compareA[CNT_W-1:8];
            `CPT_OFS_FLAGS: begin
               next_state.rdata[`CPT_FL_A] = state.flagA;
               next_state.rdata[`CPT_FL_P] = state.flagP;
            end
            default: next_state.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state.ctrl0 <= `CPT_RST_BYTE;
         state.ctrl1 <= `CPT_RST_BYTE;
         state.compareA <= `CPT_RST_CMPA;
         state.flagA <= 1'b0;
         state.flagP <= 1'b0;
         state.onDelayed <= 1'b0;
         state.outLevel <= 1'b0;
         state.pinOut <= 1'b0;
         state.pinOe <= 1'b0;
         state.rdata <= 32'h0;
      end else begin
         state <= next_state;
      end
   end

   assign apbRsp.prdata = state.rdata;
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = access && !mapped;
   assign compareAFlag = state.flagA;
   assign comparePFlag = state.flagP;
   assign timerPinOut = state.pinOut;
   assign timerPinOe = state.pinOe;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic readHigh;
   assign readHigh = setup && apbReq.paddr == `CPT_OFS_CNT_HI;

   a_restart_zero: assert property (onRise |=> count == '0)
      else $error("counter not zeroed on timer-on rise");
   a_off_holds: assert property (!timerOn && !$past(timerOn) |=> $stable(count))
      else $error("counter moved while timer off");
   a_high_zero: assert property (readHigh |=> state.rdata[31:CNT_W-8] == '0 && state.rdata[CNT_W-9:0] == $past(count[CNT_W-1:8]))
      else $error("counter high byte read wrong");
   a_p_flag_none: assert property (isCompareLike(mode) && clearSelect && !state.flagP |=> !state.flagP)
      else $error("compare-P flag set with clear-select high");
   a_a_clears: assert property (run && !onRise && clearOnA && eventA |=> count == '0 && state.flagA)
      else $error("comparator A match did not clear counter");
   a_p_clears: assert property (run && !onRise && !clearOnA && hitP && !isPwm(mode) |=> count == '0 && state.flagP && state.flagA == ($past(state.flagA) || $past(eventA)))
      else $error("comparator P match did not clear and flag");
   a_ovf_noflag: assert property (isCompareLike(mode) && clearSelect && state.compareA == '0 && !state.flagA |=> !state.flagA)
      else $error("compare-A flag set on overflow");
   a_timer_pin: assert property (mode == CPT_MODE_TMR |=> !timerPinOe)
      else $error("pin driven in timer mode");
   a_load_init: assert property (mode == CPT_MODE_CMP && onRise |=> timerPinOut == (outputControl ^ outputPolarity))
      else $error("output not loaded on timer-on rise");
   a_cmp_toggle: assert property (mode == CPT_MODE_CMP && !onRise && eventA && action == CPT_ACT_TOGGLE |=> state.outLevel != $past(state.outLevel))
      else $error("toggle action did not toggle");
   a_p_no_pin: assert property (mode == CPT_MODE_CMP && !onRise && !eventA ##1 mode == CPT_MODE_CMP |-> $stable(state.outLevel))
      else $error("compare output changed without A match");
   a_pwm_full: assert property (isPwm(mode) && action == CPT_ACT_HIGH && dutyValue > {1'b0, count} |=> timerPinOut == $past(outputControl ^ outputPolarity))
      else $error("PWM output inactive below duty");
   a_pwm_force: assert property (isPwm(mode) && action == CPT_ACT_LOW |=> timerPinOut == $past(outputControl ^ outputPolarity))
      else $error("PWM forced active level wrong");
   a_pwm_runs: assert property (isPwm(mode) && timerOn && !onRise && action == CPT_ACT_NONE && !hitA && !hitP |=> count == CNT_W'($past(count) + 1'b1))
      else $error("PWM counter stopped while output forced");

   c_cmp_toggle: cover property (mode == CPT_MODE_CMP && eventA && action == CPT_ACT_TOGGLE);
   c_pwm_period: cover property (isPwm(mode) && !periodDutySwap && hitP);
   c_pwm_swap: cover property (isPwm(mode) && periodDutySwap && hitA);
   c_flag_race: cover property (eventA && writeTaken && apbReq.paddr == `CPT_OFS_FLAGS);

endmodule : cpt_timer
`default_nettype wire

// *** test/cpt_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cpt_cfg.svh"

module cpt_timer_tb
   import cpt_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   cpt_apb_req_t apbReq = '0;
   cpt_apb_rsp_t apbRsp;
   logic compareAFlag;
   logic comparePFlag;
   logic timerPinOut;
   logic timerPinOe;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h56b05256;

   always #25 clock = ~clock;

   cpt_timer dut (
      .clock(clock),
      .rst(rst),
      .apbReq(apbReq),
      .apbRsp(apbRsp),
      .compareAFlag(compareAFlag),
      .comparePFlag(comparePFlag),
      .timerPinOut(timerPinOut),
      .timerPinOe(timerPinOe)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic stop_test();
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : check

   // Ceiling well above the roughly 9000 cycles the sequence needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge clock);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= wd;
      @(posedge clock);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 50);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wreg

   task automatic rreg(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rreg

   // Timer is switched off first so the final write is a clean timer-on rise
   task automatic setup(input logic [1:0] mode, input logic [1:0] act, input logic oc, input logic pol,
                        input logic swap, input logic clr, input logic [9:0] cmpa, input logic [2:0] per);
      wreg(`CPT_OFS_CTRL0, {28'h0, 1'b0, per});
      wreg(`CPT_OFS_CTRL1, {24'h0, mode, act, oc, pol, swap, clr});
      wreg(`CPT_OFS_CMPA_LO, {24'h0, cmpa[7:0]});
      wreg(`CPT_OFS_CMPA_HI, {30'h0, cmpa[9:8]});
      wreg(`CPT_OFS_FLAGS, 32'h3);
      wreg(`CPT_OFS_CTRL0, {28'h0, 1'b1, per});
   endtask : setup

   task automatic wait_flag(input logic p, input int lim);
      int n;
      n = 0;
      @(negedge clock);
      while ((p ? comparePFlag : compareAFlag) !== 1'b1 && n < lim) begin
         @(negedge clock);
         n++;
      end
      check("flag raised", 1'b1, p ? comparePFlag : compareAFlag);
   endtask : wait_flag

   // High count over one whole period does not depend on where the window starts
   task automatic pwm_case(input logic swap, input logic [2:0] per, input logic [9:0] cmpa, input logic [1:0] act,
                           input logic oc, input logic pol, input logic clr, input int win, input int expHi,
                           input logic flg);
      int n;
      setup(CPT_MODE_PWM, act, oc, pol, swap, clr, cmpa, per);
      repeat (win) @(negedge clock);
      n = 0;
      repeat (win) begin
         @(negedge clock);
         if (timerPinOut === 1'b1)
            n++;
      end
      check("pwm high count", expHi, n);
      check("pwm pin enable", 1'b1, timerPinOe);
      if (flg) begin
         wreg(`CPT_OFS_FLAGS, 32'h3);
         wait_flag(1'b0, win + 20);
         wait_flag(1'b1, win + 20);
      end
   endtask : pwm_case

   initial begin
      logic [31:0] r;
      logic [31:0] lo;
      logic e;
      int t0;
      int d;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 7; a++) begin
         rreg(8'(a * 4), r);
         check("reset value", 32'h0, r);
      end
      wreg(`CPT_OFS_CNT_LO, 32'hff);
      rreg(`CPT_OFS_CNT_LO, r);
      check("counter read-only", 32'h0, r);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      check("unmapped error", 1'b1, e);
      check("unmapped data", 32'h0, r);
      repeat (4) begin
         seed = lfsr(seed);
         wreg(`CPT_OFS_CMPA_LO, seed);
         wreg(`CPT_OFS_CMPA_HI, seed >> 8);
         rreg(`CPT_OFS_CMPA_LO, r);
         check("compare low", {24'h0, seed[7:0]}, r);
         rreg(`CPT_OFS_CMPA_HI, r);
         check("compare high", {30'h0, seed[9:8]}, r);
      end
      // Every compare action from an initial high level; P would match first if it cleared
      for (int i = 0; i < 4; i++) begin
         setup(CPT_MODE_CMP, 2'(i), 1'b1, 1'b0, 1'b0, 1'b1, 10'd300, 3'd1);
         repeat (2) @(negedge clock);
         check("initial level", 1'b1, timerPinOut);
         check("compare pin enable", 1'b1, timerPinOe);
         wait_flag(1'b0, 400);
         check("action result", (i == 1 || i == 3) ? 1'b0 : 1'b1, timerPinOut);
         check("no P flag", 1'b0, comparePFlag);
         rreg(`CPT_OFS_CNT_HI, r);
         rreg(`CPT_OFS_CNT_LO, lo);
         check("cleared by A", 1'b1, {r[1:0], lo[7:0]} < 10'd300);
      end
      setup(CPT_MODE_CMP, CPT_ACT_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0, 10'd40, 3'd1);
      wait_flag(1'b0, 200);
      check("toggle on A", 1'b1, timerPinOut);
      wait_flag(1'b1, 200);
      check("A flag held", 1'b1, compareAFlag);
      check("P leaves pin", 1'b1, timerPinOut);
      t0 = cycles;
      wreg(`CPT_OFS_FLAGS, 32'h2);
      wait_flag(1'b1, 200);
      check("P period", 32'd128, cycles - t0);
      setup(CPT_MODE_TMR, CPT_ACT_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b1, 10'd50, 3'd1);
      wait_flag(1'b0, 200);
      check("timer mode pin free", 1'b0, timerPinOe);
      check("timer mode no P", 1'b0, comparePFlag);
      // Undefined mode counts like compare mode but must leave the pin undriven
      setup(2'd1, CPT_ACT_TOGGLE, 1'b1, 1'b0, 1'b0, 1'b1, 10'd50, 3'd1);
      wait_flag(1'b0, 200);
      check("undefined mode pin free", 1'b0, timerPinOe);
      setup(CPT_MODE_CMP, CPT_ACT_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b1, 10'd0, 3'd1);
      repeat (700) @(posedge clock);
      wreg(`CPT_OFS_CTRL0, 32'h1);
      rreg(`CPT_OFS_CNT_HI, r);
      rreg(`CPT_OFS_CNT_LO, lo);
      check("high unused bits", 32'h0, r[31:2]);
      check("counter value", 1'b1, {r[1:0], lo[7:0]} >= 10'd695 && {r[1:0], lo[7:0]} <= 10'd712);
      rreg(`CPT_OFS_CNT_LO, r);
      check("held when off", lo, r);
      wreg(`CPT_OFS_CTRL0, 32'h9);
      rreg(`CPT_OFS_CNT_LO, r);
      check("restart from zero", 1'b1, r < 32'd16);
      repeat (1100) @(posedge clock);
      check("no A flag at zero", 1'b0, compareAFlag);
      seed = lfsr(seed);
      d = 1 + int'(seed % 255);
      pwm_case(1'b0, 3'd2, 10'(d), 2'd2, 1'b1, 1'b0, 1'b1, 256, d, 1'b1);
      pwm_case(1'b0, 3'd2, 10'(d), 2'd2, 1'b0, 1'b0, 1'b0, 256, 256 - d, 1'b1);
      pwm_case(1'b0, 3'd2, 10'(d), 2'd2, 1'b1, 1'b1, 1'b0, 256, 256 - d, 1'b1);
      pwm_case(1'b0, 3'd2, 10'd256, 2'd2, 1'b1, 1'b0, 1'b0, 256, 256, 1'b0);
      pwm_case(1'b1, 3'd1, 10'd200, 2'd2, 1'b1, 1'b0, 1'b1, 200, 128, 1'b1);
      pwm_case(1'b0, 3'd2, 10'(d), 2'd0, 1'b1, 1'b0, 1'b0, 256, 0, 1'b1);
      pwm_case(1'b0, 3'd2, 10'(d), 2'd1, 1'b1, 1'b0, 1'b0, 256, 256, 1'b1);
      // Reset in mid-run while the timer drives the pin
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check("reset pin enable", 1'b0, timerPinOe);
      check("reset A flag", 1'b0, compareAFlag);
      check("reset P flag", 1'b0, comparePFlag);
      rreg(`CPT_OFS_CTRL1, r);
      check("reset control", 32'h0, r);
      rreg(`CPT_OFS_CMPA_LO, r);
      check("reset compare low", 32'h0, r);
      stop_test();
   end
endmodule : cpt_timer_tb

`default_nettype wire
